// ===== common/hub_defines.svh
`ifndef HUB_DEFINES_SVH
`define HUB_DEFINES_SVH

`define HUB_CLK_PERIOD_NS      4
`define HUB_RESET_DET_NS       2500
`define HUB_RESET_DET_CYC      ((`HUB_RESET_DET_NS + `HUB_CLK_PERIOD_NS - 1) / `HUB_CLK_PERIOD_NS)
`define HUB_DEV_CHIRP_US       1000
`define HUB_DEV_CHIRP_CYC      ((`HUB_DEV_CHIRP_US * 1000 + `HUB_CLK_PERIOD_NS - 1) / `HUB_CLK_PERIOD_NS)
`define HUB_HOST_CHIRP_MIN_NS  2500
`define HUB_HOST_CHIRP_MIN_CYC ((`HUB_HOST_CHIRP_MIN_NS + `HUB_CLK_PERIOD_NS - 1) / `HUB_CLK_PERIOD_NS)
`define HUB_HOST_WAIT_US       1000
`define HUB_HOST_WAIT_CYC      ((`HUB_HOST_WAIT_US * 1000) / `HUB_CLK_PERIOD_NS)
`define HUB_HOST_CHIRP_EDGES   6

`define HUB_SPI_READ_CMD       8'h03
`define HUB_SPI_START_ADDR     8'h00
`define HUB_SPI_HDR_BITS       16
`define HUB_SPI_HALF_CYC       4
`define HUB_CFG_BYTES          7
`define HUB_CFG_VID_MSB        55
`define HUB_CFG_PID_MSB        39
`define HUB_CFG_DID_MSB        23
`define HUB_CFG_OPT_MSB        7

`define HUB_ADDR_RST           7'h00
`define HUB_CFG_RST            8'h00
`define HUB_ALT_RST            8'h00
`define HUB_ALT_MULTI          8'h01

`define HUB_PID_OUT            4'h1
`define HUB_PID_IN             4'h9
`define HUB_PID_SETUP          4'hD

`endif

// ===== common/hub_pkg.sv
package hub_pkg;

  typedef enum logic [6:0] {
    ST_LOAD       = 7'h01,
    ST_NOVBUS     = 7'h02,
    ST_WAIT_RESET = 7'h04,
    ST_CHIRP      = 7'h08,
    ST_HOST_CHIRP = 7'h10,
    ST_FULL       = 7'h20,
    ST_HIGH       = 7'h40
  } attach_state_e;

  typedef enum logic [2:0] {
    LD_IDLE  = 3'h1,
    LD_SHIFT = 3'h2,
    LD_DONE  = 3'h4
  } loader_state_e;

  typedef enum logic [1:0] {
    TOK_NONE  = 2'h0,
    TOK_OUT   = 2'h1,
    TOK_IN    = 2'h2,
    TOK_SETUP = 2'h3
  } token_kind_e;

endpackage

// ===== logic/cfg_eeprom_loader.sv
`timescale 1ns/1ns
`include "hub_defines.svh"

module cfg_eeprom_loader #(
  parameter int CFG_BYTES = `HUB_CFG_BYTES,
  parameter int HALF_CYC  = `HUB_SPI_HALF_CYC
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_clk_en,
  input  wire logic                   i_spi_miso,
  output logic                        o_spi_sck,
  output logic                        o_spi_cs_n,
  output logic                        o_spi_mosi,
  output logic                        o_load_done,
  output logic [CFG_BYTES*8-1:0]      o_cfg_bytes
);
  localparam int TOTAL = `HUB_SPI_HDR_BITS + CFG_BYTES * 8;
  localparam int CW    = $clog2(TOTAL + 1);
  localparam int DW    = $clog2(HALF_CYC + 1);

  hub_pkg::loader_state_e state_q, state_d;
  logic [DW-1:0]          div_q, div_d;
  logic [CW-1:0]          bit_q, bit_d;
  logic                   sck_q, sck_d, cs_n_q, cs_n_d, done_q, done_d, tick;
  logic [15:0]            hdr_q, hdr_d;
  logic [CFG_BYTES*8-1:0] data_q, data_d;

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    sck_d   = sck_q;
    cs_n_d  = cs_n_q;
    hdr_d   = hdr_q;
    data_d  = data_q;
    done_d  = done_q;
    tick    = (div_q == DW'(HALF_CYC - 1));
    div_d   = tick ? '0 : div_q + DW'(1);
    case (state_q)
      hub_pkg::LD_IDLE: begin
        cs_n_d  = 1'b0;
        hdr_d   = {`HUB_SPI_READ_CMD, `HUB_SPI_START_ADDR};
        div_d   = '0;
        state_d = hub_pkg::LD_SHIFT;
      end
      hub_pkg::LD_SHIFT: begin
        if (tick && !sck_q) begin
          sck_d = 1'b1;
          if (bit_q >= CW'(`HUB_SPI_HDR_BITS)) begin
            data_d = {data_q[CFG_BYTES*8-2:0], i_spi_miso};
          end
        end else if (tick) begin
          sck_d = 1'b0;
          hdr_d = {hdr_q[14:0], 1'b0};
          if (bit_q == CW'(TOTAL - 1)) begin
            cs_n_d  = 1'b1;
            done_d  = 1'b1;
            state_d = hub_pkg::LD_DONE;
          end else begin
            bit_d = bit_q + CW'(1);
          end
        end
      end
      hub_pkg::LD_DONE: div_d = '0;
      default: state_d = hub_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= hub_pkg::LD_IDLE;
      div_q   <= '0;
      bit_q   <= '0;
      sck_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      hdr_q   <= '0;
      data_q  <= '0;
      done_q  <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      div_q   <= div_d;
      bit_q   <= bit_d;
      sck_q   <= sck_d;
      cs_n_q  <= cs_n_d;
      hdr_q   <= hdr_d;
      data_q  <= data_d;
      done_q  <= done_d;
    end
  end

  assign o_spi_sck   = sck_q;
  assign o_spi_cs_n  = cs_n_q;
  assign o_spi_mosi  = hdr_q[15];
  assign o_load_done = done_q;
  assign o_cfg_bytes = data_q;
endmodule

// ===== logic/port_router.sv
`timescale 1ns/1ns

module port_router #(
  parameter int PORTS = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_hs_mode,
  input  wire logic             i_multi,
  input  wire logic             i_configured,
  input  wire logic             i_packet_boundary,
  input  wire logic [PORTS-1:0] i_port_hs,
  input  wire logic [PORTS-1:0] i_port_fsls,
  input  wire logic [PORTS-1:0] i_target,
  output logic      [PORTS-1:0] o_via_repeater,
  output logic      [PORTS-1:0] o_via_translator,
  output logic      [PORTS-1:0] o_fsls_deliver,
  output logic                  o_dedicated
);
  logic [PORTS-1:0] rep_q, rep_d, xl_q, xl_d, dlv_q, dlv_d;
  logic             ded_q, ded_d, any_fsls_target;

  always_comb begin
    any_fsls_target = |(i_target & i_port_fsls);
    ded_d           = i_packet_boundary ? (i_hs_mode & i_multi) : ded_q;
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_comb begin
      rep_d[p] = rep_q[p];
      xl_d[p]  = xl_q[p];
      dlv_d[p] = dlv_q[p];
      // Switching mid-packet would truncate it on one side
      if (i_packet_boundary) begin
        // Same-speed only: high speed when hub is, otherwise everything legacy
        rep_d[p] = i_configured & (i_hs_mode ? i_port_hs[p] : (i_port_hs[p] | i_port_fsls[p]));
        xl_d[p]  = i_configured & i_hs_mode & i_port_fsls[p] & ~i_port_hs[p];
        dlv_d[p] = xl_d[p] & (i_multi ? i_target[p] : any_fsls_target);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rep_q <= '0;
      xl_q  <= '0;
      dlv_q <= '0;
      ded_q <= 1'b0;
    end else if (i_clk_en) begin
      rep_q <= rep_d;
      xl_q  <= xl_d;
      dlv_q <= dlv_d;
      ded_q <= ded_d;
    end
  end

  assign o_via_repeater   = rep_q;
  assign o_via_translator = xl_q;
  assign o_fsls_deliver   = dlv_q;
  assign o_dedicated      = ded_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  chk_route_boundary: assert property (i_clk_en && !i_packet_boundary |=> $stable(rep_q) && $stable(xl_q))
    else $error("route changed outside a packet boundary");
  chk_hs_no_xlate: assert property (i_clk_en && i_packet_boundary && i_hs_mode && i_configured
                                    |=> (rep_q & xl_q) == '0 && (xl_q & ~$past(i_port_fsls)) == '0)
    else $error("port routed through both repeater and translator");
  chk_single_share: assert property (i_clk_en && i_packet_boundary && !i_multi && i_hs_mode && i_configured
                                     && (|(i_target & i_port_fsls)) |=> dlv_q == xl_q)
    else $error("single translator traffic not sent to all slow ports");
  chk_legacy_no_xlate: assert property (i_clk_en && i_packet_boundary && !i_hs_mode |=> xl_q == '0)
    else $error("translator used with full speed upstream");
  cov_multi_route: cover property (i_multi && i_hs_mode && (|dlv_q));
endmodule

// ===== logic/hub_attach.sv
`timescale 1ns/1ns
`include "hub_defines.svh"

// What this block does
// - Read configuration bytes from serial EEPROM before any upstream attach.
// - After load and with bus power present, enable D+ pull-up, await reset.
// - During upstream bus reset, drive a device chirp announcing high speed.
// - On host answering chirp, enter high speed and drop the D+ pull-up.
// - Without an answering chirp, stay a full-speed legacy hub.
// - Every bus reset clears address and sets configuration value to zero.
// - Host sets address and configuration; ports and routing work only once configured.
// - Start single-translator; alternate setting 1 selects multi-translator mode.
// - Multi-translator mode serves each full-speed port independently.
// - Single-translator traffic to any slow port goes to all slow ports.
// - High-speed hub routes full- and low-speed ports through a translator.
// - High-speed ports on high-speed hub use only the repeater.
// - Full-speed upstream runs every downstream device at legacy speed.
// - Repeater joins only same-speed ports, both speed classes supported.
// - Repeater connectivity changes only on packet boundaries.
// - Repeater enters and leaves suspend orderly, forwards remote wakeup.
// - Token type decoding and address matching done without hub control.
// - Clocks come from the on-chip PLL; EEPROM load runs before lock, attach waits for lock.
// - Ports held at SE0 and unpowered until the hub is configured.
module hub_attach #(
  parameter int PORTS              = 4,
  parameter int RESET_DET_CYC      = `HUB_RESET_DET_CYC,
  parameter int DEV_CHIRP_CYC      = `HUB_DEV_CHIRP_CYC,
  parameter int HOST_CHIRP_MIN_CYC = `HUB_HOST_CHIRP_MIN_CYC,
  parameter int HOST_WAIT_CYC      = `HUB_HOST_WAIT_CYC,
  parameter int HOST_CHIRP_EDGES   = `HUB_HOST_CHIRP_EDGES
) (
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_pll_locked,
  input  wire logic             i_upstream_vbus_sense,
  input  wire logic             i_line_se0,
  input  wire logic             i_line_j,
  input  wire logic             i_line_k,
  input  wire logic             i_spi_miso,
  output logic                  o_spi_sck,
  output logic                  o_spi_cs_n,
  output logic                  o_spi_mosi,
  output logic                  o_cfg_loaded,
  output logic [15:0]           o_vendor_id,
  output logic [15:0]           o_product_id,
  output logic [15:0]           o_device_id,
  output logic [7:0]            o_cfg_options,
  output logic                  o_pullup_en,
  output logic                  o_chirp_k,
  output logic                  o_hs_mode,
  output logic                  o_bus_reset,
  input  wire logic             i_set_address_valid,
  input  wire logic [6:0]       i_set_address,
  input  wire logic             i_set_config_valid,
  input  wire logic [7:0]       i_set_config,
  input  wire logic             i_set_interface_valid,
  input  wire logic [7:0]       i_set_alt,
  output logic [6:0]            o_address,
  output logic [7:0]            o_config_value,
  output logic                  o_configured,
  output logic                  o_multi_translator,
  input  wire logic             i_token_valid,
  input  wire logic [3:0]       i_token_pid,
  input  wire logic [6:0]       i_token_addr,
  output logic                  o_token_match,
  output logic [1:0]            o_token_kind,
  input  wire logic             i_bus_idle_long,
  input  wire logic             i_upstream_resume,
  input  wire logic             i_downstream_wakeup,
  output logic                  o_repeater_suspend,
  output logic                  o_wakeup_upstream,
  input  wire logic [PORTS-1:0] i_port_hs,
  input  wire logic [PORTS-1:0] i_port_fsls,
  input  wire logic [PORTS-1:0] i_target,
  input  wire logic             i_packet_boundary,
  output logic      [PORTS-1:0] o_port_se0,
  output logic                  o_ports_unpowered,
  output logic      [PORTS-1:0] o_via_repeater,
  output logic      [PORTS-1:0] o_via_translator,
  output logic      [PORTS-1:0] o_fsls_deliver,
  output logic                  o_dedicated_translators
);
  localparam int TW = 20;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  logic [`HUB_CFG_BYTES*8-1:0] cfg_bytes;

  cfg_eeprom_loader #(
    .CFG_BYTES (`HUB_CFG_BYTES),
    .HALF_CYC  (`HUB_SPI_HALF_CYC)
  ) u_loader (
    .i_clock     (i_clock),
    .i_arst_n    (i_arst_n),
    .i_clk_en    (i_clk_en),
    .i_spi_miso  (i_spi_miso),
    .o_spi_sck   (o_spi_sck),
    .o_spi_cs_n  (o_spi_cs_n),
    .o_spi_mosi  (o_spi_mosi),
    .o_load_done (o_cfg_loaded),
    .o_cfg_bytes (cfg_bytes)
  );

  // First byte read lands in the top byte
  assign o_vendor_id   = cfg_bytes[`HUB_CFG_VID_MSB -: 16];
  assign o_product_id  = cfg_bytes[`HUB_CFG_PID_MSB -: 16];
  assign o_device_id   = cfg_bytes[`HUB_CFG_DID_MSB -: 16];
  assign o_cfg_options = cfg_bytes[`HUB_CFG_OPT_MSB -: 8];

  // Attach and speed negotiation
  hub_pkg::attach_state_e state_q, state_d;
  logic [TW-1:0] timer_q, timer_d, se0_q, se0_d, run_q, run_d;
  logic [3:0]    edges_q, edges_d;
  logic          pullup_q, pullup_d, chirp_q, chirp_d, hs_q, hs_d, brst_q, brst_d;
  logic          reset_evt, line_ok, operational;

  always_comb begin
    state_d   = state_q;
    timer_d   = timer_q;
    run_d     = run_q;
    edges_d   = edges_q;
    se0_d     = '0;
    reset_evt = 1'b0;
    line_ok   = edges_q[0] ? i_line_j : i_line_k;
    case (state_q)
      hub_pkg::ST_LOAD: begin
        if (o_cfg_loaded && i_pll_locked) begin
          state_d = hub_pkg::ST_NOVBUS;
        end
      end
      hub_pkg::ST_NOVBUS: begin
        if (i_upstream_vbus_sense) begin
          state_d = hub_pkg::ST_WAIT_RESET;
        end
      end
      hub_pkg::ST_WAIT_RESET, hub_pkg::ST_FULL, hub_pkg::ST_HIGH: begin
        se0_d = i_line_se0 ? se0_q + TW'(1) : '0;
        if (i_line_se0 && se0_q == TW'(RESET_DET_CYC - 1)) begin
          reset_evt = 1'b1;
          se0_d     = '0;
          timer_d   = '0;
          state_d   = hub_pkg::ST_CHIRP;
        end
      end
      hub_pkg::ST_CHIRP: begin
        timer_d = timer_q + TW'(1);
        if (timer_q == TW'(DEV_CHIRP_CYC - 1)) begin
          timer_d = '0;
          run_d   = '0;
          edges_d = '0;
          state_d = hub_pkg::ST_HOST_CHIRP;
        end
      end
      hub_pkg::ST_HOST_CHIRP: begin
        timer_d = timer_q + TW'(1);
        // Glitches shorter than the least chirp time restart the count
        run_d = line_ok ? run_q + TW'(1) : '0;
        if (line_ok && run_q == TW'(HOST_CHIRP_MIN_CYC - 1)) begin
          run_d   = '0;
          edges_d = edges_q + 4'h1;
        end
        if (edges_d == 4'(HOST_CHIRP_EDGES)) begin
          state_d = hub_pkg::ST_HIGH;
        end else if (timer_q == TW'(HOST_WAIT_CYC - 1)) begin
          state_d = hub_pkg::ST_FULL;
        end
      end
      default: state_d = hub_pkg::ST_LOAD;
    endcase
    if (!i_upstream_vbus_sense && state_q != hub_pkg::ST_LOAD) begin
      state_d = hub_pkg::ST_NOVBUS;
    end
    pullup_d = (state_d == hub_pkg::ST_WAIT_RESET) || (state_d == hub_pkg::ST_CHIRP)
             || (state_d == hub_pkg::ST_HOST_CHIRP) || (state_d == hub_pkg::ST_FULL);
    chirp_d  = (state_d == hub_pkg::ST_CHIRP);
    hs_d     = (state_d == hub_pkg::ST_HIGH);
    brst_d   = reset_evt;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q  <= hub_pkg::ST_LOAD;
      timer_q  <= '0;
      se0_q    <= '0;
      run_q    <= '0;
      edges_q  <= '0;
      pullup_q <= 1'b0;
      chirp_q  <= 1'b0;
      hs_q     <= 1'b0;
      brst_q   <= 1'b0;
    end else if (i_clk_en) begin
      state_q  <= state_d;
      timer_q  <= timer_d;
      se0_q    <= se0_d;
      run_q    <= run_d;
      edges_q  <= edges_d;
      pullup_q <= pullup_d;
      chirp_q  <= chirp_d;
      hs_q     <= hs_d;
      brst_q   <= brst_d;
    end
  end

  assign o_pullup_en = pullup_q;
  assign o_chirp_k   = chirp_q;
  assign o_hs_mode   = hs_q;
  assign o_bus_reset = brst_q;
  assign operational = (state_q == hub_pkg::ST_FULL) || (state_q == hub_pkg::ST_HIGH);

  // Enumeration state
  logic [6:0]       addr_q, addr_d;
  logic [7:0]       cfg_q, cfg_d, alt_q, alt_d;
  logic             conf_q, conf_d, multi_q, multi_d, unpw_q, unpw_d;
  logic [PORTS-1:0] se0p_q, se0p_d;

  always_comb begin
    addr_d = addr_q;
    cfg_d  = cfg_q;
    alt_d  = alt_q;
    if (operational && i_set_address_valid) begin
      addr_d = i_set_address;
    end
    if (operational && i_set_config_valid) begin
      cfg_d = i_set_config;
    end
    if (hs_q && conf_q && i_set_interface_valid) begin
      alt_d = i_set_alt;
    end
    // Reset beats a request in the same cycle
    if (reset_evt || state_d == hub_pkg::ST_NOVBUS) begin
      addr_d = `HUB_ADDR_RST;
      cfg_d  = `HUB_CFG_RST;
      alt_d  = `HUB_ALT_RST;
    end
    conf_d  = (cfg_d != `HUB_CFG_RST);
    multi_d = hs_d && conf_d && (alt_d == `HUB_ALT_MULTI);
    se0p_d  = {PORTS{~conf_d}};
    unpw_d  = ~conf_d;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q  <= `HUB_ADDR_RST;
      cfg_q   <= `HUB_CFG_RST;
      alt_q   <= `HUB_ALT_RST;
      conf_q  <= 1'b0;
      multi_q <= 1'b0;
      se0p_q  <= '1;
      unpw_q  <= 1'b1;
    end else if (i_clk_en) begin
      addr_q  <= addr_d;
      cfg_q   <= cfg_d;
      alt_q   <= alt_d;
      conf_q  <= conf_d;
      multi_q <= multi_d;
      se0p_q  <= se0p_d;
      unpw_q  <= unpw_d;
    end
  end

  assign o_address          = addr_q;
  assign o_config_value     = cfg_q;
  assign o_configured       = conf_q;
  assign o_multi_translator = multi_q;
  assign o_port_se0         = se0p_q;
  assign o_ports_unpowered  = unpw_q;

  // Token decode and address match, suspend tracking
  hub_pkg::token_kind_e kind_q, kind_d;
  logic                 match_q, match_d, susp_q, susp_d, wake_q, wake_d;

  always_comb begin
    case (i_token_pid)
      `HUB_PID_OUT:   kind_d = hub_pkg::TOK_OUT;
      `HUB_PID_IN:    kind_d = hub_pkg::TOK_IN;
      `HUB_PID_SETUP: kind_d = hub_pkg::TOK_SETUP;
      default:        kind_d = hub_pkg::TOK_NONE;
    endcase
    match_d = i_token_valid && operational && (i_token_addr == addr_q)
            && (kind_d != hub_pkg::TOK_NONE);
    susp_d  = susp_q;
    wake_d  = 1'b0;
    if (!susp_q && operational && i_bus_idle_long) begin
      susp_d = 1'b1;
    end else if (susp_q && (i_upstream_resume || i_downstream_wakeup || !operational)) begin
      susp_d = 1'b0;
      wake_d = i_downstream_wakeup && !i_upstream_resume;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kind_q  <= hub_pkg::TOK_NONE;
      match_q <= 1'b0;
      susp_q  <= 1'b0;
      wake_q  <= 1'b0;
    end else if (i_clk_en) begin
      kind_q  <= kind_d;
      match_q <= match_d;
      susp_q  <= susp_d;
      wake_q  <= wake_d;
    end
  end

  assign o_token_kind       = kind_q;
  assign o_token_match      = match_q;
  assign o_repeater_suspend = susp_q;
  assign o_wakeup_upstream  = wake_q;

  port_router #(
    .PORTS (PORTS)
  ) u_router (
    .i_clock           (i_clock),
    .i_arst_n          (i_arst_n),
    .i_clk_en          (i_clk_en),
    .i_hs_mode         (hs_q),
    .i_multi           (multi_q),
    .i_configured      (conf_q),
    .i_packet_boundary (i_packet_boundary),
    .i_port_hs         (i_port_hs),
    .i_port_fsls       (i_port_fsls),
    .i_target          (i_target),
    .o_via_repeater    (o_via_repeater),
    .o_via_translator  (o_via_translator),
    .o_fsls_deliver    (o_fsls_deliver),
    .o_dedicated       (o_dedicated_translators)
  );

  chk_attach_after_load: assert property (o_pullup_en |-> o_cfg_loaded && $past(i_upstream_vbus_sense))
    else $error("pull-up on before load or without bus power");
  chk_hs_pullup_off: assert property (o_hs_mode |-> !o_pullup_en && !o_chirp_k)
    else $error("pull-up still on in high speed");
  chk_chirp_hold: assert property ($rose(o_chirp_k) |-> o_chirp_k[*8])
    else $error("device chirp too short");
  chk_reset_clears: assert property (i_clk_en && reset_evt |=> o_config_value == 8'h00
                                     && o_address == 7'h00 && !o_configured)
    else $error("bus reset left hub addressed or configured");
  chk_reset_single: assert property (o_bus_reset |-> !o_multi_translator && alt_q == 8'h00)
    else $error("bus reset left multi translator mode");
  chk_vbus_detach: assert property (i_clk_en && !i_upstream_vbus_sense |=> !o_pullup_en)
    else $error("pull-up held without bus power");
  chk_ports_se0: assert property (!o_configured |-> o_port_se0 == '1 && o_ports_unpowered)
    else $error("ports released before configuration");
  chk_fs_fallback: assert property (i_clk_en && state_q == hub_pkg::ST_HOST_CHIRP
                                    && timer_q == TW'(HOST_WAIT_CYC - 1) && edges_d != 4'(HOST_CHIRP_EDGES)
                                    && i_upstream_vbus_sense |=> state_q == hub_pkg::ST_FULL && !o_hs_mode)
    else $error("no full speed fallback after chirp timeout");
  chk_token_match: assert property (i_clk_en && i_token_valid && operational && i_token_pid == 4'h9
                                    && i_token_addr == addr_q |=> o_token_match && o_token_kind == 2'h2)
    else $error("own token not matched");
  chk_multi_needs_hs: assert property (o_multi_translator |-> o_hs_mode && o_configured)
    else $error("multi translator mode outside high speed configuration");

  cov_hs_attach: cover property ($rose(o_hs_mode));
  cov_fs_attach: cover property (state_q == hub_pkg::ST_HOST_CHIRP ##1 state_q == hub_pkg::ST_FULL);
  cov_wakeup: cover property (o_wakeup_upstream);
endmodule

// ===== bench/usb_host_model.sv
`timescale 1ns/1ns
// Upstream host: bus reset, then optional K/J answer chirps
module usb_host_model (
  input  wire logic i_clock,
  input  wire logic i_reset_req,
  input  wire logic i_hs_host,
  input  wire logic i_chirp_k,
  output logic      o_se0,
  output logic      o_j,
  output logic      o_k
);
  initial begin
    {o_se0, o_j, o_k} = 3'h2;
    forever begin
      @(posedge i_clock);
      if (i_reset_req) begin
        {o_se0, o_j, o_k} <= 3'h4;
        repeat (12) @(posedge i_clock);
        for (int n = 0; n < 40 && i_chirp_k; n++) @(posedge i_clock);
        for (int e = 0; e < 6 && i_hs_host; e++) begin
          {o_se0, o_j, o_k} <= e[0] ? 3'h2 : 3'h1;
          repeat (6) @(posedge i_clock);
        end
        {o_se0, o_j, o_k} <= 3'h2;
      end
    end
  end
endmodule

// ===== bench/usb_hub_attach_and_tt_routing_bench.sv
`timescale 1ns/1ns
module usb_hub_attach_and_tt_routing_bench;
  logic        clk = 0, rst_n = 0, vbus = 0, rq = 0, hh = 0, bnd = 0, av = 0, cv_v = 0, iv = 0;
  logic        tv = 0, idl = 0, rsm = 0, wk = 0, ce = 1, pll = 0;
  logic [7:0]  sc = 0, alt = 0, opt, cv;
  logic [6:0]  sa = 0, ta = 0, adr;
  logic [3:0]  tp = 0, phs = 4'h1, pfs = 4'hE, tgt = 4'h2, pse0, rep, trn, dlv;
  logic [15:0] vid, pid, did;
  logic [1:0]  tk;
  logic        se0, lj, lk, ld, pu, ch, hs, br, mt, cfd, sck, cs, mo, tm, sus, wup, ded, unp;
  int          err_total = 0, checks_done = 0, n;
  always #2 clk = ~clk;
  usb_host_model u_host (.i_clock(clk), .i_reset_req(rq), .i_hs_host(hh), .i_chirp_k(ch), .o_se0(se0),
    .o_j(lj), .o_k(lk));
  hub_attach #(.RESET_DET_CYC(8), .DEV_CHIRP_CYC(16), .HOST_CHIRP_MIN_CYC(4), .HOST_WAIT_CYC(200)) u_dut (
    .i_clock(clk), .i_arst_n(rst_n), .i_clk_en(ce), .i_pll_locked(pll), .i_upstream_vbus_sense(vbus),
    .i_line_se0(se0), .i_line_j(lj), .i_line_k(lk), .i_spi_miso(1'h1), .o_spi_sck(sck), .o_spi_cs_n(cs),
    .o_spi_mosi(mo), .o_cfg_loaded(ld), .o_vendor_id(vid), .o_product_id(pid), .o_device_id(did),
    .o_cfg_options(opt), .o_pullup_en(pu), .o_chirp_k(ch), .o_hs_mode(hs), .o_bus_reset(br),
    .i_set_address_valid(av), .i_set_address(sa), .i_set_config_valid(cv_v), .i_set_config(sc),
    .i_set_interface_valid(iv), .i_set_alt(alt), .o_address(adr), .o_config_value(cv), .o_configured(cfd),
    .o_multi_translator(mt), .i_token_valid(tv), .i_token_pid(tp), .i_token_addr(ta), .o_token_match(tm),
    .o_token_kind(tk), .i_bus_idle_long(idl), .i_upstream_resume(rsm), .i_downstream_wakeup(wk),
    .o_repeater_suspend(sus), .o_wakeup_upstream(wup), .i_port_hs(phs), .i_port_fsls(pfs), .i_target(tgt),
    .i_packet_boundary(bnd), .o_port_se0(pse0), .o_ports_unpowered(unp), .o_via_repeater(rep),
    .o_via_translator(trn), .o_fsls_deliver(dlv), .o_dedicated_translators(ded));
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task load_attach;
    for (n = 0; n < 2000 && ld !== 1'h1; n++) tick(1);
    chk(ld, 1'h1);
    chk(vid, 16'hFFFF);
    chk(pid, 16'hFFFF);
    chk(did, 16'hFFFF);
    chk({opt, cs, sck, mo}, 11'h7FC);
    chk({pu, pse0}, 5'h0F);
    vbus <= 1'h1;
    tick(2);
    chk(pu, 1'h0);
    ce <= 1'h0;
    pll <= 1'h1;
    tick(4);
    chk(pu, 1'h0);
    ce <= 1'h1;
    tick(3);
    chk(pu, 1'h1);
    $display("test load and attach done");
  endtask
  task bus_reset(input logic up);
    hh <= up;
    rq <= 1'h1;
    tick(1);
    rq <= 1'h0;
    tick(1);
    for (n = 0; n < 30 && ch !== 1'h1; n++) tick(1);
    chk({ch, br}, 2'h3);
    tick(260);
    chk(hs, up);
    chk(pu, !up);
    chk({adr, cv}, 15'h0000);
    chk(mt, 1'h0);
  endtask
  task enumerate(input logic multi);
    av <= 1'h1;
    sa <= 7'h05;
    tick(1);
    av <= 1'h0;
    cv_v <= 1'h1;
    sc <= 8'h01;
    tick(1);
    cv_v <= 1'h0;
    iv <= multi;
    alt <= 8'h01;
    tick(1);
    iv <= 1'h0;
    tick(2);
    chk({adr, cfd}, 8'h0B);
    chk({pse0, unp}, 5'h00);
    chk(mt, multi);
  endtask
  task route(input logic [3:0] er, input logic [3:0] et, input logic [3:0] ed, input logic ex);
    bnd <= 1'h1;
    tick(1);
    bnd <= 1'h0;
    tick(2);
    chk(rep, er);
    chk(trn, et);
    chk(dlv, ed);
    chk(ded, ex);
  endtask
  task token_wake;
    tv <= 1'h1;
    tp <= 4'h9;
    ta <= 7'h05;
    tick(1);
    tv <= 1'h0;
    tick(1);
    chk({tm, tk}, 3'h6);
    tv <= 1'h1;
    tp <= 4'hD;
    ta <= 7'h06;
    tick(1);
    tv <= 1'h0;
    tick(1);
    chk({tm, tk}, 3'h3);
    idl <= 1'h1;
    tick(1);
    idl <= 1'h0;
    tick(1);
    chk({sus, wup}, 2'h2);
    wk <= 1'h1;
    tick(1);
    wk <= 1'h0;
    tick(1);
    chk({sus, wup}, 2'h1);
  endtask
  task power_loss;
    vbus <= 1'h0;
    tick(2);
    chk({pu, cfd}, 2'h0);
    chk({pse0, unp}, 5'h1F);
    $display("test power loss done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    $display("ERROR %0t run limit reached", $time);
    report_and_stop;
  end
  initial begin
    tick(12);
    rst_n <= 1'h1;
    load_attach;
    bus_reset(1'h1);
    enumerate(1'h1);
    route(4'h1, 4'hE, 4'h2, 1'h1);
    tgt <= 4'h4;
    tick(3);
    chk(dlv, 4'h2);
    token_wake;
    $display("test high speed multi done");
    bus_reset(1'h1);
    enumerate(1'h0);
    route(4'h1, 4'hE, 4'hE, 1'h0);
    $display("test high speed single done");
    bus_reset(1'h0);
    enumerate(1'h0);
    route(4'hF, 4'h0, 4'h0, 1'h0);
    $display("test full speed done");
    power_loss;
    report_and_stop;
  end
endmodule
